// [gpc_top.sv]
/*
 * gpc_top: register-controlled configuration of eleven general purpose
 * pins, reached over an AXI4-Lite slave.
 * Assumes pin levels arrive asynchronously; internal MII, LED and
 * default-function signals come from logic on CLK.
 */
`timescale 1ns/1ns
module gpc_top #(
	parameter int NPINS = 11
) (
	// clock, reset, enable
	input wire logic CLK,
	input wire logic RESETN,
	input wire logic CE,
	// axi4-lite write address and data
	input wire logic [11:0] AWADDR,
	input wire logic AWVALID,
	output logic AWREADY,
	input wire logic [31:0] WDATA,
	input wire logic [3:0] WSTRB,
	input wire logic WVALID,
	output logic WREADY,
	// axi4-lite write response
	output logic [1:0] BRESP,
	output logic BVALID,
	input wire logic BREADY,
	// axi4-lite read
	input wire logic [11:0] ARADDR,
	input wire logic ARVALID,
	output logic ARREADY,
	output logic [31:0] RDATA,
	output logic [1:0] RRESP,
	output logic RVALID,
	input wire logic RREADY,
	// pins
	input wire logic [NPINS-1:0] PIN_I,
	output logic [NPINS-1:0] PIN_O,
	output logic [NPINS-1:0] PIN_OE,
	// device configuration
	input wire logic PHY_CHOICE_STRAP,
	input wire logic EEPROM_PRESENT,
	input wire logic EEPROM_INDICATOR_SELECT,
	input wire logic LIGHT_RESET,
	input wire logic USB_RESET,
	input wire logic MIRROR_ENABLE,
	// internal functions offered to the pins
	input wire logic [7:0] DFLT_O,
	input wire logic [7:0] DFLT_OE,
	input wire logic [7:0] MII_MIRROR,
	input wire logic MII_RXD2,
	input wire logic MII_CRS,
	input wire logic LED_FUNC_O,
	// wake and interrupt qualification
	input wire logic [NPINS-1:0] WAKE_ENABLE,
	output logic [NPINS-1:0] IRQ_ELIGIBLE,
	output logic [NPINS-1:0] WAKE_ARMED,
	output logic INDICATOR_SELECT
);
	gpc_pkg::gpc_upper_t up_q;
	gpc_pkg::gpc_lower_t lo_q;
	logic [NPINS-1:0] s1_q, s2_q, s3_q, lvl_q;
	logic ext_mii_q;
	logic aw_rdy_q, w_rdy_q, ar_rdy_q, bvalid_q, rvalid_q;
	logic [11:0] awaddr_q;
	logic [31:0] wdata_q, rdata_q;
	logic [3:0] wstrb_q;
	logic [1:0] bresp_q, rresp_q;
	logic [NPINS-1:0] pin_o_q, pin_oe_q, irq_q, wake_q;
	logic [NPINS-1:0] pin_o_d, pin_oe_d, gp_mode;
	logic [NPINS-1:0] pin_dir, pin_drv, pin_val;

	// byte-lane merge of a write into an old word
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[b*8 +: 8] = nw[b*8 +: 8];
			end
		end
		return r;
	endfunction

	// address decode
	wire aw_take = AWVALID & aw_rdy_q;
	wire w_take = WVALID & w_rdy_q;
	wire ar_take = ARVALID & ar_rdy_q;
	wire wr_go = ~aw_rdy_q & ~w_rdy_q & ~bvalid_q;
	wire wr_up = (awaddr_q == gpc_pkg::UPPER_OFS);
	wire wr_lo = (awaddr_q == gpc_pkg::LOWER_OFS);
	wire rd_up = (ARADDR == gpc_pkg::UPPER_OFS);
	wire rd_lo = (ARADDR == gpc_pkg::LOWER_OFS);

	// read words; data fields always show the filtered pin levels
	wire [31:0] up_word = {up_q.ind_sel, 13'h0000, up_q.fn, 5'h00,
		up_q.drv, 1'b0, up_q.dir, 1'b0, lvl_q[10:8]};
	wire [31:0] lo_word = {lo_q.dfl, lo_q.drv, lo_q.dir,
		lvl_q[7:0]};
	wire [31:0] up_wr = merge(up_word, wdata_q, wstrb_q);
	wire [31:0] lo_wr = merge(lo_word, wdata_q, wstrb_q);
	// data latches take only their strobed byte; readback never shows them
	wire [31:0] up_val_wr = merge({29'h0, up_q.val}, wdata_q, wstrb_q);
	wire [31:0] lo_val_wr = merge({24'h0, lo_q.val}, wdata_q, wstrb_q);
	wire [31:0] rd_word = rd_up ? up_word : (rd_lo ? lo_word : 32'h00000000);
	wire eeprom_sel = EEPROM_PRESENT & EEPROM_INDICATOR_SELECT;
	wire lite_rst = LIGHT_RESET | USB_RESET;

	// per-pin configuration views
	assign pin_dir = {up_q.dir, lo_q.dir};
	assign pin_drv = {up_q.drv, lo_q.drv};
	assign pin_val = {up_q.val, lo_q.val};

	// pin synchroniser: a change counts once stages two and three agree
	// the hold-on-disagree filter costs a cycle of lag but rejects glitches
	always_ff @(posedge CLK) begin
		if (CE) begin
			s1_q <= PIN_I;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (!RESETN) begin
				lvl_q <= s3_q;
			end else begin
				lvl_q <= (s2_q & ~(s2_q ^ s3_q)) | (lvl_q & (s2_q ^ s3_q));
			end
		end
	end

	// strap is caught while reset is held and frozen afterwards
	// the strap is a static board level, so it needs no synchroniser;
	// a later change only counts after the next reset
	always_ff @(posedge CLK) begin
		if (CE && !RESETN) begin
			ext_mii_q <= PHY_CHOICE_STRAP;
		end
	end

	// pin function selection
	generate
		for (genvar n = 0; n < NPINS; n++) begin : g_pin
			logic gp_o, gp_oe;
			// open-drain only pulls low; push-pull drives both levels
			assign gp_o = pin_drv[n] & pin_val[n];
			assign gp_oe = pin_dir[n] & (pin_drv[n] | ~pin_val[n]);
			if (n < 8) begin : g_lo
				assign gp_mode[n] = ~lo_q.dfl[n] & ~ext_mii_q;
				wire mir = MIRROR_ENABLE & ~ext_mii_q;
				assign pin_o_d[n] = gp_mode[n] ? gp_o :
					(mir ? MII_MIRROR[n] : DFLT_O[n]);
				assign pin_oe_d[n] = gp_mode[n] ? gp_oe :
					(mir ? 1'b1 : DFLT_OE[n]);
			end else if (n == 8) begin : g_p8
				wire [1:0] fn = up_q.fn;
				assign gp_mode[n] = (fn == gpc_pkg::P8_GPIO);
				assign pin_o_d[n] = (fn == gpc_pkg::P8_LED) ? LED_FUNC_O :
					(fn == gpc_pkg::P8_RXD2) ? MII_RXD2 :
					(fn == gpc_pkg::P8_CRS) ? MII_CRS : gp_o;
				assign pin_oe_d[n] = gp_mode[n] ? gp_oe : 1'b1;
			end else begin : g_up
				assign gp_mode[n] = 1'b1;
				assign pin_o_d[n] = gp_o;
				assign pin_oe_d[n] = gp_oe;
			end
		end
	endgenerate

	// registered pin drive and wake qualification
	// reset also waits for CE, so a frozen block keeps every flop
	always_ff @(posedge CLK) begin
		if (CE && !RESETN) begin
			pin_o_q <= '0;
			pin_oe_q <= '0;
			irq_q <= '0;
			wake_q <= '0;
		end else if (CE) begin
			pin_o_q <= pin_o_d;
			pin_oe_q <= pin_oe_d;
			irq_q <= gp_mode & ~pin_dir;
			wake_q <= gp_mode & ~pin_dir & WAKE_ENABLE;
		end
	end

	// configuration registers; light reset outranks a software write
	always_ff @(posedge CLK) begin
		if (CE && !RESETN) begin
			up_q.ind_sel <= eeprom_sel;
			up_q.fn <= gpc_pkg::UP_FN_RST;
			up_q.drv <= gpc_pkg::UP_DRV_RST;
			up_q.dir <= gpc_pkg::UP_DIR_RST;
			up_q.val <= 3'h0;
			lo_q.dfl <= gpc_pkg::LO_DFL_RST;
			lo_q.drv <= gpc_pkg::LO_DRV_RST;
			lo_q.dir <= gpc_pkg::LO_DIR_RST;
			lo_q.val <= 8'h00;
		end else if (CE) begin
			if (wr_go && wr_up) begin
				up_q.ind_sel <= up_wr[gpc_pkg::UP_IND_SEL_POS];
				up_q.fn <= up_wr[gpc_pkg::UP_FN_POS +: 2];
				up_q.drv <= up_wr[gpc_pkg::UP_DRV_POS +: 3];
				up_q.dir <= up_wr[gpc_pkg::UP_DIR_POS +: 3];
				up_q.val <= up_val_wr[2:0];
			end
			if (lite_rst) begin
				up_q.ind_sel <= eeprom_sel;
			end
			if (wr_go && wr_lo) begin
				lo_q.dfl <= lo_wr[gpc_pkg::LO_DFL_POS +: 8];
				lo_q.drv <= lo_wr[gpc_pkg::LO_DRV_POS +: 8];
				lo_q.dir <= lo_wr[gpc_pkg::LO_DIR_POS +: 8];
				lo_q.val <= lo_val_wr[7:0];
			end
		end
	end

	// write channels: address and data taken in either order
	// a write lands one edge after both halves are in, and is answered on that same edge
	always_ff @(posedge CLK) begin
		if (CE && !RESETN) begin
			aw_rdy_q <= 1'b1;
			w_rdy_q <= 1'b1;
			bvalid_q <= 1'b0;
			bresp_q <= gpc_pkg::RESP_OKAY;
			awaddr_q <= 12'h000;
			wdata_q <= 32'h00000000;
			wstrb_q <= 4'h0;
		end else if (CE) begin
			if (aw_take) begin
				aw_rdy_q <= 1'b0;
				awaddr_q <= AWADDR;
			end
			if (w_take) begin
				w_rdy_q <= 1'b0;
				wdata_q <= WDATA;
				wstrb_q <= WSTRB;
			end
			if (wr_go) begin
				bvalid_q <= 1'b1;
				bresp_q <= (wr_up | wr_lo) ? gpc_pkg::RESP_OKAY :
					gpc_pkg::RESP_SLVERR;
			end
			if (bvalid_q && BREADY) begin
				bvalid_q <= 1'b0;
				aw_rdy_q <= 1'b1;
				w_rdy_q <= 1'b1;
			end
		end
	end

	// read channel: one read outstanding, answered the next cycle
	always_ff @(posedge CLK) begin
		if (CE && !RESETN) begin
			ar_rdy_q <= 1'b1;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h00000000;
			rresp_q <= gpc_pkg::RESP_OKAY;
		end else if (CE) begin
			if (ar_take) begin
				ar_rdy_q <= 1'b0;
				rvalid_q <= 1'b1;
				rdata_q <= rd_word;
				rresp_q <= (rd_up | rd_lo) ? gpc_pkg::RESP_OKAY :
					gpc_pkg::RESP_SLVERR;
			end
			if (rvalid_q && RREADY) begin
				rvalid_q <= 1'b0;
				ar_rdy_q <= 1'b1;
			end
		end
	end

	// outputs straight from flip-flops
	assign AWREADY = aw_rdy_q;
	assign WREADY = w_rdy_q;
	assign BVALID = bvalid_q;
	assign BRESP = bresp_q;
	assign ARREADY = ar_rdy_q;
	assign RVALID = rvalid_q;
	assign RDATA = rdata_q;
	assign RRESP = rresp_q;
	assign PIN_O = pin_o_q;
	assign PIN_OE = pin_oe_q;
	assign IRQ_ELIGIBLE = irq_q;
	assign WAKE_ARMED = wake_q;
	assign INDICATOR_SELECT = up_q.ind_sel;
endmodule

// [gpc_pkg.sv]
/*
 * gpc_pkg: shared constants and types for the general purpose pin block.
 * Assumes a 32-bit AXI4-Lite register bus with byte addressing.
 */
package gpc_pkg;
	// register byte offsets
	localparam logic [11:0] UPPER_OFS = 12'h024;
	localparam logic [11:0] LOWER_OFS = 12'h028;

	// upper register field positions
	localparam int UP_IND_SEL_POS = 31;
	localparam int UP_FN_POS = 16;
	localparam int UP_DRV_POS = 8;
	localparam int UP_DIR_POS = 4;
	localparam int UP_VAL_POS = 0;

	// lower register field positions
	localparam int LO_DFL_POS = 24;
	localparam int LO_DRV_POS = 16;
	localparam int LO_DIR_POS = 8;
	localparam int LO_VAL_POS = 0;

	// reset values
	localparam logic [7:0] LO_DFL_RST = 8'hff;
	localparam logic [7:0] LO_DRV_RST = 8'h00;
	localparam logic [7:0] LO_DIR_RST = 8'h00;
	localparam logic [2:0] UP_DRV_RST = 3'h0;
	localparam logic [2:0] UP_DIR_RST = 3'h0;
	localparam logic [1:0] UP_FN_RST = 2'h0;

	// axi responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// pin 8 function codes
	typedef enum logic [1:0] {
		P8_GPIO = 2'h0,
		P8_LED = 2'h1,
		P8_RXD2 = 2'h2,
		P8_CRS = 2'h3
	} gpc_p8fn_t;

	// upper pin configuration (pins 8..10)
	typedef struct packed {
		logic ind_sel;
		logic [1:0] fn;
		logic [2:0] drv;
		logic [2:0] dir;
		logic [2:0] val;
	} gpc_upper_t;

	// lower pin configuration (pins 0..7)
	typedef struct packed {
		logic [7:0] dfl;
		logic [7:0] drv;
		logic [7:0] dir;
		logic [7:0] val;
	} gpc_lower_t;
endpackage

// [gpc_checker.sv]
/* gpc_checker: bus, wake and indicator assertions on the gpc_top ports.
   assumes CE high whenever the block is checked. */
`timescale 1ns/1ns
module gpc_checker #(
	parameter int NPINS = 11
) (
	// clock and reset
	input wire logic CLK,
	input wire logic RESETN,
	// register bus
	input wire logic AWREADY,
	input wire logic WREADY,
	input wire logic BVALID,
	input wire logic BREADY,
	input wire logic [1:0] BRESP,
	input wire logic [11:0] ARADDR,
	input wire logic ARVALID,
	input wire logic ARREADY,
	input wire logic [31:0] RDATA,
	input wire logic [1:0] RRESP,
	input wire logic RVALID,
	input wire logic RREADY,
	// wake and indicator
	input wire logic [NPINS-1:0] IRQ_ELIGIBLE,
	input wire logic [NPINS-1:0] WAKE_ENABLE,
	input wire logic [NPINS-1:0] WAKE_ARMED,
	input wire logic LIGHT_RESET,
	input wire logic USB_RESET,
	input wire logic EEPROM_PRESENT,
	input wire logic EEPROM_INDICATOR_SELECT,
	input wire logic INDICATOR_SELECT
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RESETN);
	logic up_q;
	wire mapped = ARADDR == gpc_pkg::UPPER_OFS || ARADDR == gpc_pkg::LOWER_OFS;
	// remember the target so the reserved mask applies to 024h only
	always_ff @(posedge CLK)
		if (ARVALID && ARREADY) up_q <= ARADDR == gpc_pkg::UPPER_OFS;
	sequence ar_take;
		ARVALID && ARREADY;
	endsequence
	chk_b_hold: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
		else $error("write response dropped");
	chk_r_hold: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
		else $error("read data dropped");
	chk_ar_busy: assert property (RVALID |-> !ARREADY)
		else $error("read taken while busy");
	chk_aw_busy: assert property (BVALID |-> !AWREADY && !WREADY)
		else $error("write taken while busy");
	chk_r_decode: assert property (ar_take |=> RVALID && RRESP ==
		($past(mapped) ? gpc_pkg::RESP_OKAY : gpc_pkg::RESP_SLVERR))
		else $error("bad read decode");
	chk_up_resv: assert property (RVALID && up_q |->
		(RDATA & 32'h7ffcf888) == 32'h0) else $error("reserved bit set");
	chk_wake_lag: assert property (
		WAKE_ARMED == (IRQ_ELIGIBLE & $past(WAKE_ENABLE)))
		else $error("wake");
	chk_ind_restore: assert property (LIGHT_RESET || USB_RESET |=>
		INDICATOR_SELECT == $past(EEPROM_PRESENT && EEPROM_INDICATOR_SELECT))
		else $error("indicator not restored");
endmodule
bind gpc_top gpc_checker #(.NPINS(NPINS)) u_chk (
	.CLK(CLK), .RESETN(RESETN),
	.AWREADY(AWREADY), .WREADY(WREADY), .BVALID(BVALID),
	.BREADY(BREADY), .BRESP(BRESP), .ARADDR(ARADDR),
	.ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA),
	.RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
	.IRQ_ELIGIBLE(IRQ_ELIGIBLE), .WAKE_ENABLE(WAKE_ENABLE),
	.WAKE_ARMED(WAKE_ARMED), .LIGHT_RESET(LIGHT_RESET),
	.USB_RESET(USB_RESET), .EEPROM_PRESENT(EEPROM_PRESENT),
	.EEPROM_INDICATOR_SELECT(EEPROM_INDICATOR_SELECT),
	.INDICATOR_SELECT(INDICATOR_SELECT)
);

// [gpc_board.sv]
/* gpc_board: board wiring at the pins.
   assumes every pin has a pull-up to the supply. */
`timescale 1ns/1ns
module gpc_board (
	// pins
	input wire logic [10:0] pin_o,
	input wire logic [10:0] pin_oe,
	output logic [10:0] pin_i
);
	// a released or open-drain high pin floats up to the pull-up level
	assign pin_i = ~pin_oe | pin_o;
endmodule

// [gpc_top_tb.sv]
/* gpc_top_tb: self-checking bench for gpc_top.
   assumes gpc_board resolves the pins. */
`timescale 1ns/1ns
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin \
	err_count++; $display("wrong value %0t: %h %h", $time, a, b); end end
module gpc_top_tb;
	localparam logic [1:0] OK = gpc_pkg::RESP_OKAY;
	localparam logic [1:0] ER = gpc_pkg::RESP_SLVERR;
	logic CLK = 1'b0, RESETN = 1'b0, CE = 1'b1;
	logic [11:0] AWADDR = '0, ARADDR = '0;
	logic [31:0] WDATA = '0, RDATA;
	logic [3:0] WSTRB = 4'hf;
	logic AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0;
	logic ARVALID = 1'b0, RREADY = 1'b0, MIRROR_ENABLE = 1'b0;
	logic PHY_CHOICE_STRAP = 1'b0, EEPROM_PRESENT = 1'b1;
	logic EEPROM_INDICATOR_SELECT = 1'b1, LIGHT_RESET = 1'b0;
	logic USB_RESET = 1'b0, MII_RXD2 = 1'b1, MII_CRS = 1'b0;
	logic LED_FUNC_O = 1'b0;
	logic [7:0] DFLT_O = '0, DFLT_OE = '0, MII_MIRROR = '0;
	logic [10:0] WAKE_ENABLE = '0, PIN_I, PIN_O, PIN_OE;
	logic [10:0] IRQ_ELIGIBLE, WAKE_ARMED;
	logic AWREADY, WREADY, BVALID, ARREADY, RVALID, INDICATOR_SELECT;
	logic [1:0] BRESP, RRESP;
	int err_count = 0, num_checks = 0, cyc = 0;
	gpc_top u_dut (
		.CLK(CLK), .RESETN(RESETN), .CE(CE),
		.AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
		.WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY),
		.BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY),
		.ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY),
		.RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
		.PIN_I(PIN_I), .PIN_O(PIN_O), .PIN_OE(PIN_OE),
		.PHY_CHOICE_STRAP(PHY_CHOICE_STRAP),
		.EEPROM_PRESENT(EEPROM_PRESENT),
		.EEPROM_INDICATOR_SELECT(EEPROM_INDICATOR_SELECT),
		.LIGHT_RESET(LIGHT_RESET), .USB_RESET(USB_RESET),
		.MIRROR_ENABLE(MIRROR_ENABLE),
		.DFLT_O(DFLT_O), .DFLT_OE(DFLT_OE), .MII_MIRROR(MII_MIRROR),
		.MII_RXD2(MII_RXD2), .MII_CRS(MII_CRS), .LED_FUNC_O(LED_FUNC_O),
		.WAKE_ENABLE(WAKE_ENABLE), .IRQ_ELIGIBLE(IRQ_ELIGIBLE),
		.WAKE_ARMED(WAKE_ARMED), .INDICATOR_SELECT(INDICATOR_SELECT)
	);
	gpc_board u_board (.pin_o(PIN_O), .pin_oe(PIN_OE), .pin_i(PIN_I));
	initial forever #5 CLK = ~CLK;
	task automatic report_and_stop;
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// a hung handshake ends the run as a failure
	always @(posedge CLK) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			report_and_stop;
		end
	end
	task automatic st;
		repeat (6) @(posedge CLK);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d,
		input logic [1:0] e);
		@(posedge CLK);
		{AWADDR, WDATA} <= {a, d};
		{AWVALID, WVALID} <= 2'h3;
		do begin
			@(posedge CLK);
			if (AWREADY) AWVALID <= 1'b0;
			if (WREADY) WVALID <= 1'b0;
		end while (BVALID !== 1'b1);
		// answer held off a cycle so it must stand until taken
		BREADY <= 1'b1;
		@(posedge CLK);
		`CHK({BVALID, BRESP}, {1'b1, e});
		BREADY <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] d,
		input logic [1:0] e);
		@(posedge CLK);
		ARADDR <= a;
		ARVALID <= 1'b1;
		do begin
			@(posedge CLK);
			if (ARREADY) ARVALID <= 1'b0;
		end while (RVALID !== 1'b1);
		// data held off a cycle so it must stand until taken
		RREADY <= 1'b1;
		@(posedge CLK);
		`CHK({RVALID, RDATA, RRESP}, {1'b1, d, e});
		RREADY <= 1'b0;
	endtask
	task automatic t_lower;
		wr(12'h028, 32'h00ffffa5, OK);
		st;
		`CHK({PIN_OE[7:0], PIN_O[7:0]}, 16'hffa5);
		wr(12'h028, 32'h0000ffa5, OK);
		st;
		`CHK({PIN_OE[7:0], PIN_O[7:0]}, 16'h5a00);
		rd(12'h028, 32'h0000ffa5, OK);
		wr(12'h028, 32'h0, OK);
		WAKE_ENABLE <= 11'h00f;
		st;
		`CHK({IRQ_ELIGIBLE[7:0], WAKE_ARMED[7:0]}, 16'hff0f);
	endtask
	task automatic t_upper;
		wr(12'h024, 32'h7ffefffa, OK);
		st;
		rd(12'h024, 32'h00020773, OK);
		`CHK(PIN_OE[10:8], 3'h7);
		for (int k = 0; k < 4; k++) begin
			{LED_FUNC_O, MII_RXD2, MII_CRS} <= k == 0 ? 3'h7 : 3'h4 >> (k - 1);
			wr(12'h024, {14'h0, k[1:0], 16'h0770}, OK);
			st;
			`CHK(PIN_O[8], k != 0);
		end
	endtask
	task automatic t_ind;
		for (int i = 0; i < 2; i++) begin
			wr(12'h024, 32'h0, OK);
			`CHK(INDICATOR_SELECT, 1'b0);
			{USB_RESET, LIGHT_RESET} <= i ? 2'h2 : 2'h1;
			@(posedge CLK);
			{USB_RESET, LIGHT_RESET} <= 2'h0;
			st;
			`CHK(INDICATOR_SELECT, 1'b1);
		end
	endtask
	task automatic t_mirror;
		wr(12'h028, 32'hffffffa5, OK);
		{MIRROR_ENABLE, MII_MIRROR} <= 9'h13c;
		st;
		`CHK({PIN_OE[7:0], PIN_O[7:0]}, 16'hff3c);
		{MIRROR_ENABLE, DFLT_O, DFLT_OE} <= 17'h0c30f;
		// a low clock enable must freeze the pin drive
		CE <= 1'b0;
		st;
		`CHK({PIN_OE[7:0], PIN_O[7:0]}, 16'hff3c);
		CE <= 1'b1;
		st;
		`CHK({PIN_OE[7:0], PIN_O[7:0]}, 16'h0fc3);
	endtask
	task automatic t_strap;
		{RESETN, PHY_CHOICE_STRAP} <= 2'h1;
		st;
		RESETN <= 1'b1;
		wr(12'h028, 32'h00ffffa5, OK);
		MIRROR_ENABLE <= 1'b1;
		st;
		`CHK({PIN_OE[7:0], PIN_O[7:0]}, 16'h0fc3);
		`CHK(IRQ_ELIGIBLE[7:0], 8'h00);
	endtask
	initial begin
		repeat (2) @(posedge CLK);
		RESETN <= 1'b1;
		// let the pin synchroniser settle before the first readback
		st;
		rd(12'h028, 32'hff0000ff, OK);
		rd(12'h024, 32'h80000007, OK);
		t_lower;
		t_upper;
		t_ind;
		wr(12'h030, 32'hffffffff, ER);
		rd(12'h026, 32'h0, ER);
		t_mirror;
		t_strap;
		report_and_stop;
	end
endmodule
